// ### bench/prl_ctrl_assertions.sv
// port checker of the program load controller
module prl_ctrl_assertions (
  input wire logic              clk_i,
  input wire logic              sys_rst_i,
  input wire logic              reset_pin_i,
  input wire logic              program_store_strobe_n_i,
  input wire logic              load_strobe_n_i,
  input wire logic              external_access_n_i,
  input wire logic              programming_voltage_i,
  input wire logic              load_mode_sel_hi_i,
  input wire logic              load_mode_sel_mid_i,
  input wire logic              load_mode_sel_lo_i,
  input wire prl_pkg::prl_req_t par_req_i,
  input wire prl_pkg::prl_byte_t rx_i,
  input wire prl_pkg::prl_byte_t tx_o,
  input wire logic              tx_ready_i,
  input wire logic [7:0]        par_data_o,
  input wire logic              par_data_oe_o,
  input wire logic              par_busy_o,
  input wire logic [7:0]        memory_control_reg_o,
  input wire logic              security_lock_o,
  input wire logic              serial_mode_o,
  input wire logic [1:0]        range_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import prl_pkg::*;
  logic        h, m, l, ld, pg, sc, rg, vf, vx, seen;
  logic [11:0] bc;
  assign {h, m, l} = {load_mode_sel_hi_i, load_mode_sel_mid_i, load_mode_sel_lo_i};
  assign ld = reset_pin_i & ~program_store_strobe_n_i & ~load_strobe_n_i & programming_voltage_i;
  assign pg = ld & h & ~m;
  assign sc = ld & h & m;
  assign rg = ld & ~h & m & l;
  assign vf = reset_pin_i & external_access_n_i & ~h & ~m;
  assign vx = reset_pin_i & ~program_store_strobe_n_i & load_strobe_n_i & external_access_n_i & ~h & m;
  always_ff @(posedge clk_i)
  begin
    seen <= sys_rst_i ? 1'b0 : seen | pg | sc;
    bc <= (sys_rst_i | ~par_busy_o) ? 12'h000 : bc + 12'h001;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_prog_busy: assert property ($rose(pg) && !security_lock_o && par_req_i.addr < 16'h1000 |=> par_busy_o)
    else $error("program strobe did not start busy");
  a_busy_len: assert property ($fell(par_busy_o) |-> bc inside {[47:49], [1799:1801]})
    else $error("busy length wrong");
  a_oe_on: assert property ($rose(vf) |=> par_data_oe_o)
    else $error("verify did not drive data");
  a_oe_off: assert property (!vf && !vx |=> !par_data_oe_o)
    else $error("data driven outside verify");
  a_lock_mask: assert property ((vf && security_lock_o) [*3] |-> par_data_o == 8'hff)
    else $error("locked verify leaked data");
  a_sec_lock: assert property ($rose(sc) |-> ##[1:2] security_lock_o)
    else $error("security set ignored");
  a_range_init: assert property ((pg || sc) && !seen |-> ##[1:2] range_o == 2'h1)
    else $error("first strobe did not set range");
  a_ctrl_load: assert property ($rose(rg) && par_req_i.addr == 16'h0000 && !security_lock_o
    |-> ##[1:49] memory_control_reg_o == par_req_i.data)
    else $error("control register not loaded");
  a_reg_refuse: assert property (rg && par_req_i.addr[15:8] != 8'h00 |=> $stable(memory_control_reg_o))
    else $error("bad register address accepted");
  a_tx_hold: assert property (tx_o.valid && !tx_ready_i |=> tx_o.valid && $stable(tx_o.data))
    else $error("reply byte dropped while stalled");
  a_serial_cr: assert property (rx_i.valid && rx_i.data == 8'h0d && reset_pin_i && !program_store_strobe_n_i
    && load_strobe_n_i |-> ##[1:2] serial_mode_o)
    else $error("carriage return did not enter serial mode");
endmodule : prl_ctrl_assertions
bind prl_ctrl prl_ctrl_assertions prl_ctrl_assertions_inst (.clk_i, .sys_rst_i, .reset_pin_i,
  .program_store_strobe_n_i, .load_strobe_n_i, .external_access_n_i, .programming_voltage_i,
  .load_mode_sel_hi_i, .load_mode_sel_mid_i, .load_mode_sel_lo_i, .par_req_i, .rx_i, .tx_o, .tx_ready_i,
  .par_data_o, .par_data_oe_o, .par_busy_o, .memory_control_reg_o, .security_lock_o, .serial_mode_o, .range_o);

// ### bench/prl_ctrl_tb.sv
// self-checking bench of the program load controller
module prl_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import prl_pkg::*;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        reset_pin_i = 1'b0;
  logic        program_store_strobe_n_i = 1'b1;
  logic        load_strobe_n_i = 1'b1;
  logic        external_access_n_i = 1'b1;
  logic        programming_voltage_i = 1'b0;
  logic [2:0]  msel = 3'h7;
  logic        load_mode_sel_hi_i, load_mode_sel_mid_i, load_mode_sel_lo_i;
  prl_req_t    par_req_i = '0;
  prl_byte_t   rx_i = '0;
  prl_byte_t   tx_o, got;
  logic        tx_ready_i, par_data_oe_o, par_busy_o, security_lock_o, serial_mode_o, oe_d;
  logic        slow = 1'b0;
  logic [7:0]  port_in_i = 8'h00;
  logic [7:0]  par_data_o, port_out_o, memory_control_reg_o, v;
  logic [7:0]  pq[$], sq[$], k[5];
  logic [39:0] key_o;
  logic [1:0]  range_o;
  logic [3:0]  partition_o;
  logic [15:0] a;
  logic [31:0] seed = 32'hae97;
  int          error_cnt = 0, checks_done = 0;
  assign {load_mode_sel_hi_i, load_mode_sel_mid_i, load_mode_sel_lo_i} = msel;
  prl_ctrl prl_ctrl_inst (.clk_i, .sys_rst_i, .ce_i, .reset_pin_i, .program_store_strobe_n_i,
    .load_strobe_n_i, .external_access_n_i, .programming_voltage_i, .load_mode_sel_hi_i,
    .load_mode_sel_mid_i, .load_mode_sel_lo_i, .par_req_i, .par_data_o, .par_data_oe_o, .par_busy_o,
    .rx_i, .tx_o, .tx_ready_i, .port_in_i, .port_out_o, .memory_control_reg_o, .key_o,
    .security_lock_o, .serial_mode_o, .range_o, .partition_o);
  prl_host prl_host_inst (.clk_i, .slow_i(slow), .tx_i(tx_o), .tx_ready_o(tx_ready_i), .got_o(got));
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  task automatic prog(input logic [2:0] md, input logic [15:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    msel = md;
    par_req_i = '{addr: ad, data: d};
    programming_voltage_i = 1'b1;
    tick(1);
    load_strobe_n_i = 1'b0;
    tick(2);
    // expanded cycles run far longer, so wait on busy itself
    while (par_busy_o !== 1'b0 && n < 3000)
    begin
      tick(1);
      n++;
    end
    if (n >= 3000)
      error_cnt++;
    load_strobe_n_i = 1'b1;
    programming_voltage_i = 1'b0;
    msel = 3'h7;
    tick(2);
  endtask : prog
  task automatic ver(input logic [2:0] md, input logic [15:0] ad, input logic [7:0] e);
    par_req_i.addr = ad;
    tick(2);
    pq.push_back(e);
    msel = md;
    tick(4);
    msel = 3'h7;
    tick(2);
  endtask : ver
  task automatic sb(input logic [7:0] b);
    rx_i = '{valid: 1'b1, data: b};
    tick(1);
    rx_i = '0;
    tick(12);
  endtask : sb
  // sends the low n bytes of w, most significant first; echo notes each as an expected reply
  task automatic sbn(input logic [47:0] w, input int n, input logic echo);
    for (int i = n - 1; i >= 0; i--)
    begin
      if (echo)
        sq.push_back(w[8*i +: 8]);
      sb(w[8*i +: 8]);
    end
  endtask : sbn
  task automatic reenter();
    sys_rst_i = 1'b1;
    tick(3);
    sys_rst_i = 1'b0;
    sb(8'h0d);
  endtask : reenter
  always @(posedge clk_i)
  begin
    if (par_data_oe_o === 1'b1 && oe_d !== 1'b1 && pq.size() > 0)
      check(par_data_o, pq.pop_front());
    if (got.valid === 1'b1)
      check(got.data, (sq.size() > 0) ? sq.pop_front() : ~got.data);
    oe_d = par_data_oe_o;
  end
  initial
  begin
    #300us;
    error_cnt++;
    results();
  end
  initial
  begin
    tick(3);
    sys_rst_i = 1'b0;
    check(8'(range_o), 8'h00);
    reset_pin_i = 1'b1;
    tick(2);
    program_store_strobe_n_i = 1'b0;
    tick(2);
    a = rnd() & 16'h0fff;
    v = 8'(rnd());
    prog(3'h4, a, v);
    check(8'(range_o), 8'h01);
    check(8'(partition_o), 8'h01);
    ver(3'h0, a, v);
    prog(3'h2, a | 16'h7000, ~v);
    ver(3'h2, a | 16'h7000, ~v);
    ver(3'h0, a, v);
    v = 8'(rnd()) & 8'hfe;
    prog(3'h3, 16'h0000, v);
    check(memory_control_reg_o, v);
    ver(3'h3, 16'h0000, v);
    prog(3'h3, 16'h0100, ~v);
    check(memory_control_reg_o, v);
    prog(3'h3, 16'h0000, 8'h01);
    check(8'(security_lock_o), 8'h01);
    ver(3'h0, a, 8'hff);
    sys_rst_i = 1'b1;
    tick(3);
    sys_rst_i = 1'b0;
    prog(3'h6, 16'h0000, 8'h00);
    check(8'(security_lock_o), 8'h01);
    check(8'(range_o), 8'h01);
    sys_rst_i = 1'b1;
    tick(3);
    sys_rst_i = 1'b0;
    slow = 1'b1;
    sb(8'h0d);
    check(8'(serial_mode_o), 8'h01);
    v = 8'(rnd()) & 8'hfe;
    sb(8'h57);
    sb(v);
    check(memory_control_reg_o, v);
    sq.push_back(v);
    sb(8'h52);
    sb(8'h5a);
    check(8'(security_lock_o), 8'h01);
    sb(8'h55);
    check(8'(security_lock_o), 8'h00);
    v = 8'(rnd());
    sb(8'h50);
    sb(v);
    check(port_out_o, v);
    port_in_i = 8'(rnd());
    sq.push_back(port_in_i);
    sb(8'h47);
    sb(8'h4b);
    for (int i = 0; i < 5; i++)
    begin
      k[i] = 8'(rnd());
      sb(k[i]);
    end
    for (int i = 0; i < 5; i++)
      check(key_o[39-8*i -: 8], k[i]);
    v = 8'(rnd());
    sbn({8'h46, 8'h01, 8'h00, 8'h00, 8'h04, v}, 6, 1'b0);
    repeat (4)
      sq.push_back(v);
    sbn({8'h00, 8'h44, 8'h01, 8'h00, 8'h00, 8'h04}, 5, 1'b0);
    tick(40);
    // one matching and one wrong byte: only the wrong one is answered
    sq.push_back(8'h45);
    sbn({8'h00, 8'h56, 8'h01, 8'h00, v, ~v}, 5, 1'b0);
    reenter();
    sq.push_back(8'h4c);
    sbn({16'h0000, 8'h54, 8'h4c, 8'h02, 8'h00}, 4, 1'b0);
    a = rnd();
    sbn({32'h0000_0000, a}, 2, 1'b1);
    // a load streams until reset, so leave it and read the bytes back
    reenter();
    sq.push_back(a[15:8]);
    sq.push_back(a[7:0]);
    sbn({8'h00, 8'h44, 8'h02, 8'h00, 8'h00, 8'h02}, 5, 1'b0);
    tick(40);
    tick(20);
    check(8'(pq.size() + sq.size()), 8'h00);
    results();
  end
endmodule : prl_ctrl_tb

// ### bench/prl_host.sv
// serial host model: takes reply bytes, stalling when asked
module prl_host (
  input  wire logic               clk_i,
  input  wire logic               slow_i,
  input  wire prl_pkg::prl_byte_t tx_i,
  output logic                    tx_ready_o,
  output prl_pkg::prl_byte_t      got_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import prl_pkg::*;
  logic [1:0] cnt = 2'h0;
  always_ff @(posedge clk_i)
    cnt <= cnt + 2'h1;
  // a slow host accepts one byte in four cycles
  assign tx_ready_o = !slow_i || cnt == 2'h0;
  assign got_o = '{valid: tx_i.valid & tx_ready_o, data: tx_i.data};
endmodule : prl_host

// ### include/prl_params.svh
// constants of the program load controller
`ifndef PRL_PARAMS_SVH
`define PRL_PARAMS_SVH
`define PRL_CLK_MHZ        100
`define PRL_CR_CHAR        8'h0d
`define PRL_CMD_C          8'h43
`define PRL_CMD_D          8'h44
`define PRL_CMD_F          8'h46
`define PRL_CMD_G          8'h47
`define PRL_CMD_K          8'h4b
`define PRL_CMD_L          8'h4c
`define PRL_CMD_P          8'h50
`define PRL_CMD_R          8'h52
`define PRL_CMD_T          8'h54
`define PRL_CMD_U          8'h55
`define PRL_CMD_V          8'h56
`define PRL_CMD_W          8'h57
`define PRL_CMD_Z          8'h5a
`define PRL_NORMAL_LIMIT   16'h1000
`define PRL_EXP_LIMIT      16'h8000
`define PRL_KEY_BASE       8'h01
`define PRL_KEY_COUNT      3'h5
`define PRL_MEMORY_CONTROL_REG_ADDR      8'h00
`define PRL_MEMORY_CONTROL_REG_RESET     8'h00
`define PRL_MEMORY_CONTROL_REG_LOCK_BIT  0
`define PRL_RANGE_8K       2'h1
`define PRL_PART_4K        4'h1
`define PRL_NORMAL_WAIT    16'h0030
`define PRL_EXP_WAIT       16'h0708
`define PRL_CRC_POLY       16'ha001
`define PRL_MATCH_OK       8'h2e
`define PRL_MATCH_BAD      8'h45
`endif

// ### include/prl_pkg.sv
// types of the program load controller
package prl_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } prl_req_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } prl_byte_t;
  typedef enum logic [2:0] {
    PRL_CYC_NONE, PRL_CYC_PROG, PRL_CYC_SEC, PRL_CYC_VERIFY,
    PRL_CYC_PROG_EXP, PRL_CYC_VERIFY_EXP, PRL_CYC_PROG_REG, PRL_CYC_VERIFY_REG
  } prl_cycle_t;
endpackage : prl_pkg

// ### logic/prl_ctrl.sv
// program load controller: parallel load port and serial command interpreter
`include "prl_params.svh"
module prl_ctrl #(
  parameter int ADDR_W = 15
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             ce_i,
  input  wire logic             reset_pin_i,
  input  wire logic             program_store_strobe_n_i,
  input  wire logic             load_strobe_n_i,
  input  wire logic             external_access_n_i,
  input  wire logic             programming_voltage_i,
  input  wire logic             load_mode_sel_hi_i,
  input  wire logic             load_mode_sel_mid_i,
  input  wire logic             load_mode_sel_lo_i,
  input  wire prl_pkg::prl_req_t par_req_i,
  output logic      [7:0]       par_data_o,
  output logic                  par_data_oe_o,
  output logic                  par_busy_o,
  input  wire prl_pkg::prl_byte_t rx_i,
  output prl_pkg::prl_byte_t      tx_o,
  input  wire logic             tx_ready_i,
  input  wire logic [7:0]       port_in_i,
  output logic      [7:0]       port_out_o,
  output logic      [7:0]       memory_control_reg_o,
  output logic      [39:0]      key_o,
  output logic                  security_lock_o,
  output logic                  serial_mode_o,
  output logic      [1:0]       range_o,
  output logic      [3:0]       partition_o
);
  import prl_pkg::*;

  if (ADDR_W < 15 || ADDR_W > 16)
  begin : g_addr_w_check
    $error("prl_ctrl: ADDR_W must cover 32 kbytes");
  end

  typedef enum {S_IDLE, S_ARG, S_FILL, S_DUMP, S_CRC, S_SEND} prl_state_t;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ `PRL_CRC_POLY) : (r >> 1);
    return r;
  endfunction : crc_step

  // cycle decode in load mode (reset pin held, store strobe low); normal verify needs only the reset pin
  wire load_mode  = reset_pin_i & ~program_store_strobe_n_i;
  wire vpp        = programming_voltage_i;
  wire acc_hi     = external_access_n_i;
  wire [2:0] sel  = {load_mode_sel_hi_i, load_mode_sel_mid_i, load_mode_sel_lo_i};
  wire strobe     = ~load_strobe_n_i;
  wire cyc_prog   = load_mode & strobe & vpp & sel[2:1] == 2'h2;
  wire cyc_sec    = load_mode & strobe & vpp & sel[2:1] == 2'h3;
  wire cyc_pexp   = load_mode & strobe & vpp & sel == 3'h2;
  wire cyc_preg   = load_mode & strobe & vpp & sel == 3'h3 & par_req_i.addr[15:8] == 8'h00;
  wire cyc_ver    = reset_pin_i & acc_hi & ~vpp & sel[2:1] == 2'h0;
  wire cyc_vexp   = load_mode & ~strobe & acc_hi & ~vpp & sel == 3'h2;
  wire cyc_vreg   = load_mode & ~strobe & acc_hi & ~vpp & sel == 3'h3;
  wire any_prog   = cyc_prog | cyc_pexp | cyc_preg | cyc_sec;
  wire in_normal  = par_req_i.addr < `PRL_NORMAL_LIMIT;
  wire in_exp     = par_req_i.addr < `PRL_EXP_LIMIT;

  logic [7:0]  memory_control_reg;
  logic [39:0] key;
  logic        lock;
  logic        first_done;
  logic        par_active;
  logic        prev_strobe;
  logic [15:0] wait_cnt;
  prl_state_t  state;
  logic [7:0]  cmd;
  logic [2:0]  arg_cnt;
  logic [15:0] ptr;
  logic [15:0] len;
  logic [15:0] crc;
  logic        trace;
  logic        verifying;
  logic        mem_pend;

  // memory port shared by parallel and serial sides; address and data follow the serial side once serial_mode_o is set
  wire par_we  = prev_strobe == 1'b0 & ((cyc_prog & in_normal) | (cyc_pexp & in_exp));
  wire ser_we  = (state == S_FILL) | (state == S_IDLE & serial_mode_o & rx_i.valid & cmd == `PRL_CMD_L & arg_cnt == 3'h3);
  wire mem_we  = (par_we | ser_we) & ~lock;
  wire [15:0] mem_addr = load_mode & ~serial_mode_o ? par_req_i.addr : ptr;
  wire [7:0]  mem_wdata = load_mode & ~serial_mode_o ? par_req_i.data : (state == S_FILL ? cmd : rx_i.data);
  wire [7:0]  mem_rdata;
  wire [15:0] crc_next   = crc_step(crc, mem_rdata);
  wire        in_stream  = arg_cnt == 3'h3 & (cmd == `PRL_CMD_L | cmd == `PRL_CMD_V);
  wire        ser_cmd    = state == S_IDLE & serial_mode_o & rx_i.valid & ~in_stream;
  wire        ser_lock   = ser_cmd & rx_i.data == `PRL_CMD_Z;
  wire        ser_unlock = ser_cmd & rx_i.data == `PRL_CMD_U;
  wire        sec_set    = cyc_sec & ~prev_strobe;

  prl_mem #(.ADDR_W(ADDR_W)) prl_mem_inst (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr[ADDR_W-1:0]),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  assign memory_control_reg_o = memory_control_reg;
  assign key_o                = key;
  assign security_lock_o      = lock;
  assign par_busy_o           = wait_cnt != 16'h0000;

  // parallel side: strobe edges, register loads, verify drive
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      memory_control_reg          <= `PRL_MEMORY_CONTROL_REG_RESET;
      key           <= '0;
      lock          <= 1'b0;
      first_done    <= 1'b0;
      prev_strobe   <= 1'b0;
      wait_cnt      <= '0;
      range_o       <= '0;
      partition_o   <= '0;
      par_data_o    <= '0;
      par_data_oe_o <= 1'b0;
      par_active    <= 1'b0;
    end
    else if (ce_i)
    begin
      prev_strobe <= any_prog;
      par_active  <= load_mode & strobe;
      if (wait_cnt != 16'h0000)
        wait_cnt <= wait_cnt - 16'h0001;
      if (any_prog & ~prev_strobe)
      begin
        wait_cnt <= cyc_pexp ? `PRL_EXP_WAIT : `PRL_NORMAL_WAIT;
        if (!first_done)
        begin
          first_done  <= 1'b1;
          range_o     <= `PRL_RANGE_8K;
          partition_o <= `PRL_PART_4K;
        end
        if (cyc_sec)
          lock <= 1'b1;
        if (cyc_preg)
        begin
          if (par_req_i.addr[7:0] == `PRL_MEMORY_CONTROL_REG_ADDR)
            memory_control_reg <= par_req_i.data;
          else if (par_req_i.addr[7:0] - `PRL_KEY_BASE < 8'(`PRL_KEY_COUNT))
            key[8*(par_req_i.addr[2:0]-3'h1) +: 8] <= par_req_i.data;
        end
      end
      if (memory_control_reg[`PRL_MEMORY_CONTROL_REG_LOCK_BIT] & ~ser_unlock)
        lock <= 1'b1;
      if (ser_lock)
        lock <= 1'b1;
      else if (ser_unlock & ~sec_set)
      begin
        lock <= 1'b0;
        memory_control_reg[`PRL_MEMORY_CONTROL_REG_LOCK_BIT] <= 1'b0;
      end
      if (state == S_ARG & cmd == `PRL_CMD_W & rx_i.valid)
        memory_control_reg <= rx_i.data;
      if (state == S_ARG & cmd == `PRL_CMD_K & rx_i.valid)
        key <= {key[31:0], rx_i.data};
      par_data_oe_o <= cyc_ver | cyc_vexp | cyc_vreg;
      par_data_o    <= lock ? 8'hff : (cyc_vreg ? memory_control_reg : mem_rdata);
    end
  end

  // serial interpreter
  logic [7:0] next_tx;
  logic       send_req;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state         <= S_IDLE;
      serial_mode_o <= 1'b0;
      cmd           <= '0;
      arg_cnt       <= '0;
      ptr           <= '0;
      len           <= '0;
      crc           <= '0;
      trace         <= 1'b0;
      verifying     <= 1'b0;
      mem_pend      <= 1'b0;
      tx_o          <= '0;
      port_out_o    <= '0;
    end
    else if (ce_i)
    begin
      if (tx_ready_i)
        tx_o.valid <= 1'b0;
      mem_pend <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (!serial_mode_o)
          begin
            if (load_mode & ~par_active & rx_i.valid & rx_i.data == `PRL_CR_CHAR)
              serial_mode_o <= 1'b1;
          end
          else if (rx_i.valid)
          begin
            if (trace)
              tx_o <= '{valid: 1'b1, data: rx_i.data};
            if (arg_cnt == 3'h3 & (cmd == `PRL_CMD_L | cmd == `PRL_CMD_V))
            begin
              ptr <= ptr + 16'h0001;
              if (cmd == `PRL_CMD_V)
              begin
                mem_pend <= 1'b1;
                len      <= {8'h00, rx_i.data};
              end
            end
            else
            begin
              cmd     <= rx_i.data;
              arg_cnt <= 3'h0;
              case (rx_i.data)
                `PRL_CMD_T: trace <= ~trace;
                `PRL_CMD_R: tx_o  <= '{valid: 1'b1, data: memory_control_reg};
                `PRL_CMD_G: tx_o  <= '{valid: 1'b1, data: port_in_i};
                `PRL_CMD_C:
                begin
                  ptr   <= '0;
                  crc   <= 16'hffff;
                  state <= S_CRC;
                end
                `PRL_CMD_D, `PRL_CMD_L, `PRL_CMD_V, `PRL_CMD_F, `PRL_CMD_K,
                `PRL_CMD_W, `PRL_CMD_P: state <= S_ARG;
                default: ;
              endcase
            end
          end
          else if (mem_pend & mem_rdata != len[7:0])
            tx_o <= '{valid: 1'b1, data: `PRL_MATCH_BAD};
        end
        S_ARG:
        begin
          if (rx_i.valid)
          begin
            arg_cnt <= arg_cnt + 3'h1;
            if (cmd == `PRL_CMD_P)
            begin
              port_out_o <= rx_i.data;
              state      <= S_IDLE;
            end
            else if (cmd == `PRL_CMD_W)
              state <= S_IDLE;
            else if (cmd == `PRL_CMD_K)
            begin
              if (arg_cnt == `PRL_KEY_COUNT - 3'h1)
                state <= S_IDLE;
            end
            else if (arg_cnt == 3'h0)
              ptr <= {rx_i.data, 8'h00};
            else if (arg_cnt == 3'h1)
            begin
              ptr[7:0] <= rx_i.data;
              if (cmd == `PRL_CMD_L | cmd == `PRL_CMD_V)
              begin
                arg_cnt <= 3'h3;
                state   <= S_IDLE;
              end
            end
            else if (arg_cnt == 3'h2)
              len <= {rx_i.data, 8'h00};
            else if (arg_cnt == 3'h3)
            begin
              len[7:0] <= rx_i.data;
              if (cmd == `PRL_CMD_D)
                state <= S_DUMP;
            end
            else
            begin
              cmd   <= rx_i.data;
              state <= S_FILL;
            end
          end
        end
        S_FILL:
        begin
          ptr <= ptr + 16'h0001;
          len <= len - 16'h0001;
          if (len == 16'h0001 | len == 16'h0000)
            state <= S_IDLE;
        end
        S_DUMP, S_SEND:
        begin
          if (!tx_o.valid & state == S_SEND)
          begin
            tx_o  <= '{valid: 1'b1, data: mem_rdata};
            ptr   <= ptr + 16'h0001;
            len   <= len - 16'h0001;
            state <= len == 16'h0001 ? S_IDLE : S_DUMP;
          end
          else if (state == S_DUMP)
            state <= len == 16'h0000 ? S_IDLE : S_SEND;
        end
        S_CRC:
        begin
          ptr <= ptr + 16'h0001;
          if (ptr != 16'h0000)
            crc <= crc_next;
          if (ptr == `PRL_EXP_LIMIT)
          begin
            tx_o  <= '{valid: 1'b1, data: crc_next[7:0]};
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule : prl_ctrl

// ### logic/prl_mem.sv
// byte-wide embedded memory with registered read data
module prl_mem #(
  parameter int ADDR_W = 15
) (
  input  wire logic              clk_i,
  input  wire logic              ce_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  output logic      [7:0]        rdata_o
);
  logic [7:0] store [0:(1<<ADDR_W)-1];

  if (ADDR_W < 13 || ADDR_W > 16)
  begin : g_addr_w_check
    $error("prl_mem: ADDR_W out of range");
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      if (we_i)
        store[addr_i] <= wdata_i;
      rdata_o <= store[addr_i];
    end
  end
endmodule : prl_mem
